/* rtl/ppc_defs.vh */
// register offsets, field positions, mode codes and reset values for the
// port 2 / port 3 pin configuration block; definitions only
`ifndef PPC_DEFS_VH
`define PPC_DEFS_VH

// register addresses on the cpu register space
`define PPC_ADDR_P2_LOW      8'hE9
`define PPC_ADDR_P3_HIGH     8'hEA
`define PPC_ADDR_P3_LOW      8'hEB

// reset values
`define PPC_RST_P2_LOW       8'h00
`define PPC_RST_P3_HIGH      6'h00
`define PPC_RST_P3_LOW       8'h00

// two-bit pin mode codes
`define PPC_MODE_IN          2'h0
`define PPC_MODE_IN_PU       2'h1
`define PPC_MODE_OUT_PP      2'h2
`define PPC_MODE_ALT         2'h3

// port 3 high-byte field positions
`define PPC_P3H_LCD_SEGMENT_35_BIT    5
`define PPC_P3H_LCD_SEGMENT_34_BIT    4
`define PPC_P3H_RX_LSB       2
`define PPC_P3H_TX_LSB       0
`define PPC_P3H_WIDTH        6

// port 3 low-byte field positions for pins 1 and 0
`define PPC_P3L_PIN1_LSB     2
`define PPC_P3L_PIN0_LSB     0

`endif

/* rtl/ppc_pin_config.v */
// port 2 pins 0-4 and port 3 pins 0,1 (timer/segment) and serial
// rx/tx pin configuration, with the three control registers
// assumes a single-cycle cpu register strobe on clk, read data sampled
// one cycle after the read strobe
// timer, segment and serial sources share clk and are used as levels;
// only the rx pin is asynchronous and gets a synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defs.vh"

// Behaviour
// - analog channel 4 field decodes four modes
// - port 2 pins 3..1 fields, same encoding
// - port 2 pin 0 field, code 11 analog
// - port 3 pin 1 timer A or segment 35
// - port 3 pin 0 timer B or segment 34
// - serial rx/tx pin modes, rx feeds the receiver in the two input modes only
module ppc_pin_config (
  input  wire       clk,
  input  wire       srst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [1:0] p2_pin4_mode,
  output reg  [4:0] p2_out_en,
  output reg  [4:0] p2_pull_up_en,
  output reg  [4:0] p2_analog_sel,
  output reg        p3_pin1_out_en,
  output reg        p3_pin1_pull_up_en,
  output reg        p3_pin1_alt_out,
  output reg        p3_pin0_out_en,
  output reg        p3_pin0_pull_up_en,
  output reg        p3_pin0_alt_out,
  input  wire       timer_a_output,
  input  wire       timer_a_pwm_output,
  input  wire       timer_a_pwm_sel,
  input  wire       timer_b_pwm_output,
  input  wire       lcd_segment_35,
  input  wire       lcd_segment_34,
  input  wire       serial_tx_data,
  input  wire       serial_rx_drive,
  input  wire       rx_pin_in,
  output reg        rx_pin_out_en,
  output reg        rx_pin_pull_up_en,
  output reg        rx_pin_alt_out,
  output reg        rx_to_receiver,
  output reg        tx_pin_out_en,
  output reg        tx_pin_pull_up_en,
  output reg        tx_pin_alt_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // pin drives whenever the mode is push-pull or alternate output
  function drives;
    input [1:0] mode;
    begin
      drives = (mode == `PPC_MODE_OUT_PP) || (mode == `PPC_MODE_ALT);
    end
  endfunction

  // pull-up only in the input-with-pull-up mode; driving modes drop it
  function pulls;
    input [1:0] mode;
    begin
      pulls = (mode == `PPC_MODE_IN_PU);
    end
  endfunction

  // code 11 hands the pin over to its alternate function
  function is_alt;
    input [1:0] mode;
    begin
      is_alt = (mode == `PPC_MODE_ALT);
    end
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************

  // configuration state; the pin 4 field lives outside this block
  reg  [7:0] p2_low_q;
  reg  [5:0] p3_high_q;
  reg  [7:0] p3_low_q;
  reg        rx_sync2_q;
  reg        rx_sync1_b_q;

  // cpu writes; only six bits of the high register exist
  // unmapped addresses fall to the default and are dropped
  always @(posedge clk) begin
    if (srst) begin
      p2_low_q  <= `PPC_RST_P2_LOW;
      p3_high_q <= `PPC_RST_P3_HIGH;
      p3_low_q  <= `PPC_RST_P3_LOW;
    end else if (reg_wr) begin
      case (reg_addr)
        `PPC_ADDR_P2_LOW:  p2_low_q  <= reg_wdata;
        `PPC_ADDR_P3_HIGH: p3_high_q <= reg_wdata[5:0];
        `PPC_ADDR_P3_LOW:  p3_low_q  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses and unused bits answer zero
  // reads change no state, so a stray read strobe is harmless
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PPC_ADDR_P2_LOW:  reg_rdata <= p2_low_q;
        `PPC_ADDR_P3_HIGH: reg_rdata <= {2'h0, p3_high_q};
        `PPC_ADDR_P3_LOW:  reg_rdata <= p3_low_q;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // rx pin comes from outside: two flops before anything reads it
  // the first stage may go metastable; only the second is read
  always @(posedge clk) begin
    if (srst) begin
      rx_sync1_b_q <= 1'b0;
      rx_sync2_q   <= 1'b0;
    end else begin
      rx_sync1_b_q <= rx_pin_in;
      rx_sync2_q   <= rx_sync1_b_q;
    end
  end

  // ****************************************************************
  // port 2 pin decode
  // ****************************************************************

  // mode field of pin n; pin 4 field comes from the p2_pin4_mode input
  wire [9:0] p2_modes = {p2_pin4_mode, p2_low_q};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_p2
      // this pin's two-bit field, picked once
      wire [1:0] fld = p2_modes[2*gi+1 -: 2];

      always @(posedge clk) begin
        if (srst) begin
          p2_out_en[gi]     <= 1'b0;
          p2_pull_up_en[gi] <= 1'b0;
          p2_analog_sel[gi] <= 1'b0;
        end else begin
          // analog routing leaves the digital driver off, so an
          // analog pin is never fought by its own output stage
          p2_out_en[gi]     <= (fld == `PPC_MODE_OUT_PP);
          p2_pull_up_en[gi] <= pulls(fld);
          p2_analog_sel[gi] <= is_alt(fld);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // port 3 pin decode
  // ****************************************************************

  // field slices of the two port 3 registers
  wire [1:0] p3_pin1_mode = p3_low_q[`PPC_P3L_PIN1_LSB +: 2];
  wire [1:0] p3_pin0_mode = p3_low_q[`PPC_P3L_PIN0_LSB +: 2];
  wire [1:0] rx_mode      = p3_high_q[`PPC_P3H_RX_LSB +: 2];
  wire [1:0] tx_mode      = p3_high_q[`PPC_P3H_TX_LSB +: 2];
  // timer A offers a plain output and a pwm output; the timer itself
  // says which one is live, this block only forwards it
  wire       timer_a_src  = timer_a_pwm_sel ? timer_a_pwm_output
                                            : timer_a_output;

  // alternate sources are registered so every output leaves a flop;
  // costs one cycle of latency on timer and segment waveforms
  always @(posedge clk) begin
    if (srst) begin
      p3_pin1_out_en     <= 1'b0;
      p3_pin1_pull_up_en <= 1'b0;
      p3_pin1_alt_out    <= 1'b0;
      p3_pin0_out_en     <= 1'b0;
      p3_pin0_pull_up_en <= 1'b0;
      p3_pin0_alt_out    <= 1'b0;
      rx_pin_out_en      <= 1'b0;
      rx_pin_pull_up_en  <= 1'b0;
      rx_pin_alt_out     <= 1'b0;
      rx_to_receiver     <= 1'b0;
      tx_pin_out_en      <= 1'b0;
      tx_pin_pull_up_en  <= 1'b0;
      tx_pin_alt_out     <= 1'b0;
    end else begin
      // pin 1: timer A or segment 35 when alternate
      p3_pin1_out_en     <= drives(p3_pin1_mode);
      p3_pin1_pull_up_en <= pulls(p3_pin1_mode);
      p3_pin1_alt_out    <= is_alt(p3_pin1_mode) &
        (p3_high_q[`PPC_P3H_LCD_SEGMENT_35_BIT] ? lcd_segment_35
                                       : timer_a_src);
      // pin 0: timer B or segment 34 when alternate
      p3_pin0_out_en     <= drives(p3_pin0_mode);
      p3_pin0_pull_up_en <= pulls(p3_pin0_mode);
      p3_pin0_alt_out    <= is_alt(p3_pin0_mode) &
        (p3_high_q[`PPC_P3H_LCD_SEGMENT_34_BIT] ? lcd_segment_34
                                       : timer_b_pwm_output);
      // serial receive pin
      rx_pin_out_en      <= drives(rx_mode);
      rx_pin_pull_up_en  <= pulls(rx_mode);
      rx_pin_alt_out     <= is_alt(rx_mode) & serial_rx_drive;
      // receiver hears the pin in both input modes;
      // output and alternate modes cut the receiver off
      rx_to_receiver     <= ~rx_mode[1] & rx_sync2_q;
      // serial transmit pin
      tx_pin_out_en      <= drives(tx_mode);
      tx_pin_pull_up_en  <= pulls(tx_mode);
      tx_pin_alt_out     <= is_alt(tx_mode) & serial_tx_data;
    end
  end

endmodule // ppc_pin_config
`default_nettype wire

/* test/ppc_periph_model.sv */
// timer, segment and serial sources plus the rx pin level
// moves 1 ns after each rising edge of the shared clock
`timescale 1ns/1ps
`default_nettype none
// ****
// source model
// ****
module ppc_periph_model (
  input  wire logic       clk,
  output wire logic [8:0] pat
);
  logic [8:0] cnt_q = 9'h000;
  // counter bits: every source toggles at its own rate
  always @(posedge clk) cnt_q <= #1 cnt_q + 9'h001;
  assign pat = cnt_q;
endmodule // ppc_periph_model
`default_nettype wire

/* test/ppc_pin_config_properties.sv */
// checker for the pin configuration block
// sees the top ports only; attached by the bind below
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module ppc_pin_config_properties (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] p2_pin4_mode,
  input wire logic [4:0] p2_out_en,
  input wire logic [4:0] p2_analog_sel,
  input wire logic       p3_pin1_alt_out,
  input wire logic       p3_pin0_alt_out,
  input wire logic       lcd_segment_35,
  input wire logic       lcd_segment_34,
  input wire logic       rx_pin_in,
  input wire logic       rx_to_receiver
);
  reg [7:0] s2_q;
  reg [7:0] sh_q;
  reg [7:0] sl_q;
  // mirror of cpu writes; high bits 7:6 dropped
  always @(posedge clk) begin
    if (srst) {s2_q, sh_q, sl_q} <= 24'h000000;
    else if (reg_wr && reg_addr == 8'hE9) s2_q <= reg_wdata;
    else if (reg_wr && reg_addr == 8'hEA) sh_q <= reg_wdata & 8'h3F;
    else if (reg_wr && reg_addr == 8'hEB) sl_q <= reg_wdata;
  end
  // fields of pins 3..1 equal to a mode code
  function automatic [2:0] fm(input [7:0] v, input [1:0] c);
    for (int k = 1; k < 4; k = k + 1) fm[k-1] = (v[2*k +: 2] == c);
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // cpu read of the high register
  sequence hi_rd;
    reg_rd && reg_addr == 8'hEA;
  endsequence
  chk_p2_upper: assert property (
    {p2_analog_sel[3:1], p2_out_en[3:1]} ==
    {fm($past(s2_q), 2'h3), fm($past(s2_q), 2'h2)}) else $error("p2 upper");
  chk_p2_pin0: assert property (
    {p2_analog_sel[0], p2_out_en[0]} == {$past(s2_q[1:0]) == 2'h3,
    $past(s2_q[1:0]) == 2'h2}) else $error("p2 pin 0");
  chk_pin4_chan: assert property (
    !$past(srst) |-> {p2_analog_sel[4], p2_out_en[4]} ==
    {$past(p2_pin4_mode) == 2'h3, $past(p2_pin4_mode) == 2'h2})
    else $error("pin 4 mode");
  chk_lcd_segment_35_pick: assert property (
    $past(sl_q[3:2]) == 2'h3 && $past(sh_q[5]) |->
    p3_pin1_alt_out == $past(lcd_segment_35)) else $error("pin 1 seg");
  chk_lcd_segment_34_pick: assert property (
    $past(sl_q[1:0]) == 2'h3 && $past(sh_q[4]) |->
    p3_pin0_alt_out == $past(lcd_segment_34)) else $error("pin 0 seg");
  chk_rx_feed: assert property (
    !($past(srst) || $past(srst, 2) || $past(srst, 3)) |->
    rx_to_receiver == (!$past(sh_q[3]) && $past(rx_pin_in, 3)))
    else $error("rx feed");
  chk_hi_read: assert property (
    hi_rd |=> reg_rdata == $past(sh_q)) else $error("high read");
endmodule // ppc_pin_config_properties
bind ppc_pin_config ppc_pin_config_properties i_chk (.*);
`default_nettype wire

/* test/ppc_pin_config_bench.sv */
// bench: register table, pin decode, same-cycle access, resets
// model feeds the sources; checker is bound on the dut
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module ppc_pin_config_bench;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [7:0]  wd = 8'h00;
  reg  [1:0]  p4 = 2'h0;
  wire [7:0]  rdata;
  wire [4:0]  oe, pu, an;
  wire [8:0]  pat;
  wire [12:0] p3v;
  reg  [8:0]  pq;
  reg  [1:0]  rxh;
  integer     n_fail = 0;
  integer     checks_done = 0;
  // address, data written, value read back (0x55 is unmapped)
  reg  [23:0] rows [0:3] = '{24'hE9A5A5, 24'hEAFF3F, 24'hEB0F0F, 24'h55FF00};
  // port 3 set-ups: high register, low register
  reg  [15:0] cfg [0:2] = '{16'h0F0F, 16'h320F, 16'h0406};
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  // sources as the dut samples them; rx delayed like its synchroniser
  always @(posedge clk) begin
    pq  <= pat;
    rxh <= {rxh[0], pq[0]};
  end
  ppc_periph_model i_src (.clk(clk), .pat(pat));
  ppc_pin_config i_dut (.clk(clk), .srst(srst), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdata),
    .p2_pin4_mode(p4), .p2_out_en(oe), .p2_pull_up_en(pu),
    .p2_analog_sel(an), .p3_pin1_out_en(p3v[12]),
    .p3_pin1_pull_up_en(p3v[11]), .p3_pin1_alt_out(p3v[10]),
    .p3_pin0_out_en(p3v[9]), .p3_pin0_pull_up_en(p3v[8]),
    .p3_pin0_alt_out(p3v[7]), .timer_a_output(pat[4]),
    .timer_a_pwm_output(pat[5]), .timer_a_pwm_sel(pat[6]),
    .timer_b_pwm_output(pat[3]), .lcd_segment_35(pat[1]),
    .lcd_segment_34(pat[2]), .serial_tx_data(pat[7]),
    .serial_rx_drive(pat[8]), .rx_pin_in(pat[0]),
    .rx_pin_out_en(p3v[6]), .rx_pin_pull_up_en(p3v[5]),
    .rx_pin_alt_out(p3v[4]), .rx_to_receiver(p3v[3]),
    .tx_pin_out_en(p3v[2]), .tx_pin_pull_up_en(p3v[1]),
    .tx_pin_alt_out(p3v[0]));
  // counted compare, one line on mismatch
  task chk(input string nm, input [15:0] s, e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // expected port 3 and serial pin outputs from registers and sources
  function [12:0] p3x(input [5:0] h, input [7:0] l, input [8:0] p,
                      input rxd);
    reg a1, a0;
    begin
      a1 = h[5] ? p[1] : (p[6] ? p[5] : p[4]);
      a0 = h[4] ? p[2] : p[3];
      p3x = {l[3], l[3:2] == 2'h1, l[3:2] == 2'h3 && a1,
             l[1], l[1:0] == 2'h1, l[1:0] == 2'h3 && a0,
             h[3], h[3:2] == 2'h1, h[3:2] == 2'h3 && p[8], !h[3] && rxd,
             h[1], h[1:0] == 2'h1, h[1:0] == 2'h3 && p[7]};
    end
  endfunction
  // one register cycle; strobes stand over exactly one edge
  task acc(input [7:0] a, d, input w, r, input [7:0] e);
    @(posedge clk);
    #1 {addr, wd, wr, rd} = {a, d, w, r};
    @(posedge clk);
    #1 {wr, rd} = 2'h0;
    if (r) chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  // verdict and end of run
  task summarize;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // reset, table rows, then the awkward cases
  initial begin
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 4; i = i + 1) begin
      acc(rows[i][23:16], 8'h00, 1'b0, 1'b1, 8'h00);
      acc(rows[i][23:16], rows[i][15:8], 1'b1, 1'b0, 8'h00);
      acc(rows[i][23:16], 8'h00, 1'b0, 1'b1, rows[i][7:0]);
    end
    p4 = 2'h3;
    @(posedge clk);
    #1 chk("pins", {1'b0, an, oe, pu}, 16'h4183);
    acc(8'hE9, 8'hF3, 1'b1, 1'b0, 8'h00);
    p4 = 2'h2;
    @(posedge clk);
    #1 chk("pins", {1'b0, an, oe, pu}, 16'h3600);
    // write and read together: old value comes back
    acc(8'hEB, 8'h00, 1'b1, 1'b1, 8'h0F);
    acc(8'hEB, 8'h00, 1'b0, 1'b1, 8'h00);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    acc(8'hEA, 8'h00, 1'b0, 1'b1, 8'h00);
    // port 3 and serial pins over three set-ups, sources running
    for (int j = 0; j < 3; j = j + 1) begin
      acc(8'hEA, cfg[j][15:8], 1'b1, 1'b0, 8'h00);
      acc(8'hEB, cfg[j][7:0], 1'b1, 1'b0, 8'h00);
      repeat (300) begin
        @(posedge clk);
        #1 chk("port3", {3'h0, p3v},
          {3'h0, p3x(cfg[j][13:8], cfg[j][7:0], pq, rxh[1])});
      end
    end
    summarize;
  end
endmodule // ppc_pin_config_bench
`default_nettype wire
